/* File: ldf_params.svh */
// Constants for the line delay memory: geometry, reset values and synchronised pin width.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LDF_PARAMS_SVH
`define LDF_PARAMS_SVH
`define LDF_DEPTH      8192
`define LDF_ADDR_W     13
`define LDF_DATA_W     8
`define LDF_ADDR_INIT  13'h0000
`define LDF_WORD_RST   8'h00
`define LDF_PIN_W      14
`endif

/* File: ldf_pkg.sv */
// Types shared by the line delay memory modules.
// Assumes ldf_params.svh is on the include path.
`include "ldf_params.svh"
package ldf_pkg;
  typedef logic [`LDF_ADDR_W-1:0] ldf_addr_t;
  typedef logic [`LDF_DATA_W-1:0] ldf_word_t;
endpackage : ldf_pkg

/* File: ldf_mem_if.sv */
// Carrier between the port control logic and the storage array.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface ldf_mem_if;
  import ldf_pkg::*;
  logic      we;
  ldf_addr_t wr_addr;
  ldf_word_t wr_data;
  ldf_addr_t rd_addr;
  ldf_word_t rd_data;
  modport ctrl (output we, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport array (input we, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : ldf_mem_if

/* File: ldf_array.sv */
// Flip-flop storage of one line of words, one write and one read port.
// Assumes the controller issues at most one write per mclk cycle.
`timescale 1ns/1ps
`include "ldf_params.svh"
module ldf_array
  import ldf_pkg::*;
#(
  parameter int DEPTH = `LDF_DEPTH
) (
  input wire logic mclk,  // System clock
  ldf_mem_if.array mem    // Access port
);
  import ldf_pkg::*;

  ldf_word_t store_q [DEPTH];

  if (DEPTH != (1 << $bits(ldf_addr_t))) begin : g_depth_check
    $error("ldf_array: depth must fill the address space");
  end

  // No reset on the array: contents are undefined until written
  always_ff @(posedge mclk) begin
    if (mem.we) begin
      store_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  assign mem.rd_data = store_q[mem.rd_addr];
endmodule : ldf_array

/* File: ldf_line_delay.sv */
// Line delay memory: one line of words with independent write and read ports.
// Assumes write_clock and read_clock are slow pins sampled by mclk (>= 3 mclk per phase).
`timescale 1ns/1ps
`include "ldf_params.svh"
module ldf_line_delay
  import ldf_pkg::*;
#(
  parameter int DEPTH = `LDF_DEPTH
) (
  input  wire logic          mclk,                  // 125 MHz system clock
  input  wire logic          rst_n,                 // Async reset, active low
  input  wire logic          write_clock,           // Write port clock pin
  input  wire logic          write_enable_n,        // Write enable, active low
  input  wire logic          write_counter_reset_n, // Write counter reset, active low
  input  wire ldf_pkg::ldf_word_t write_word_in,    // Write data
  input  wire logic          read_clock,            // Read port clock pin
  input  wire logic          read_enable_n,         // Read enable, active low
  input  wire logic          read_counter_reset_n,  // Read counter reset, active low
  output logic               read_word_oe_n,        // Output enable, low while driving
  output ldf_pkg::ldf_word_t read_word_out,         // Read data
  output logic               read_word_valid        // Last read word had completed write
);
  import ldf_pkg::*;

  // Counters wrap at the address width, so any other depth would alias words
  if (DEPTH != `LDF_DEPTH) begin : g_depth_check
    $error("ldf_line_delay: depth must match the address width");
  end

  logic [1:0] rst_sync_q;
  logic       rst_ok;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_q[1];

  // Pins pass two flops; a third copy of the clocks feeds edge detection only
  localparam logic [`LDF_PIN_W-1:0] PIN_IDLE = {6'h1b, `LDF_WORD_RST};
  logic [`LDF_PIN_W-1:0] pin_s1_q, pin_s2_q;
  logic                  wclk_prev_q, rclk_prev_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q    <= PIN_IDLE;
      pin_s2_q    <= PIN_IDLE;
      wclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
    end else begin
      pin_s1_q    <= {write_clock, write_enable_n, write_counter_reset_n,
                      read_clock, read_enable_n, read_counter_reset_n, write_word_in};
      pin_s2_q    <= pin_s1_q;
      wclk_prev_q <= pin_s2_q[13];
      rclk_prev_q <= pin_s2_q[10];
    end
  end

  logic      wclk_s, wen_n_s, wres_n_s, rclk_s, ren_n_s, rres_n_s;
  ldf_word_t wdata_s;
  assign {wclk_s, wen_n_s, wres_n_s, rclk_s, ren_n_s, rres_n_s, wdata_s} = pin_s2_q;

  logic w_rise, w_fall, r_rise;
  assign w_rise = wclk_s & ~wclk_prev_q;
  assign w_fall = ~wclk_s & wclk_prev_q;
  assign r_rise = rclk_s & ~rclk_prev_q;

  function automatic ldf_addr_t addr_next(input ldf_addr_t a);
    addr_next = a + ldf_addr_t'(1);
  endfunction : addr_next

  ldf_mem_if mem ();
  ldf_array #(.DEPTH(DEPTH)) u_array (.mclk(mclk), .mem(mem));

  // Write address counter
  ldf_addr_t waddr_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waddr_q <= `LDF_ADDR_INIT;
    end else if (!rst_ok) begin
      waddr_q <= `LDF_ADDR_INIT;
    end else if (w_rise && !wres_n_s) begin
      waddr_q <= `LDF_ADDR_INIT;
    end else if (w_rise && !wen_n_s) begin
      waddr_q <= addr_next(waddr_q);
    end
  end

  // Two-stage write pipe: stage a latched at rise n, b armed at rise n+1,
  // array written at the fall of n+1, so a stopped clock strands the word
  logic      pa_vld_q, pb_vld_q;
  ldf_addr_t pa_addr_q, pb_addr_q;
  ldf_word_t pa_data_q, pb_data_q;
  logic      commit;
  assign commit = w_fall & pb_vld_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pa_vld_q  <= 1'b0;
      pb_vld_q  <= 1'b0;
      pa_addr_q <= `LDF_ADDR_INIT;
      pb_addr_q <= `LDF_ADDR_INIT;
      pa_data_q <= `LDF_WORD_RST;
      pb_data_q <= `LDF_WORD_RST;
    end else if (!rst_ok) begin
      pa_vld_q <= 1'b0;
      pb_vld_q <= 1'b0;
    end else if (w_rise) begin
      pa_vld_q  <= wres_n_s & ~wen_n_s;
      pa_addr_q <= waddr_q;
      pa_data_q <= wdata_s;
      pb_vld_q  <= pa_vld_q;
      pb_addr_q <= pa_addr_q;
      pb_data_q <= pa_data_q;
    end else if (commit) begin
      pb_vld_q <= 1'b0;
    end
  end

  assign mem.we      = commit;
  assign mem.wr_addr = pb_addr_q;
  assign mem.wr_data = pb_data_q;

  // Read address counter and output stage
  ldf_addr_t raddr_q;
  logic      rd_take, rd_hazard;
  assign mem.rd_addr = raddr_q;
  assign rd_take     = r_rise & rres_n_s & ~ren_n_s;
  // Word still in the write pipe has not reached the array yet
  assign rd_hazard   = (pa_vld_q && pa_addr_q == raddr_q) ||
                       (pb_vld_q && pb_addr_q == raddr_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      raddr_q <= `LDF_ADDR_INIT;
    end else if (!rst_ok) begin
      raddr_q <= `LDF_ADDR_INIT;
    end else if (r_rise && !rres_n_s) begin
      raddr_q <= `LDF_ADDR_INIT;
    end else if (rd_take) begin
      raddr_q <= addr_next(raddr_q);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_word_oe_n  <= 1'b1;
      read_word_out   <= `LDF_WORD_RST;
      read_word_valid <= 1'b0;
    end else if (!rst_ok) begin
      read_word_oe_n  <= 1'b1;
      read_word_valid <= 1'b0;
    end else if (r_rise) begin
      read_word_oe_n <= ren_n_s;
      if (rd_take) begin
        read_word_out   <= mem.rd_data;
        read_word_valid <= ~rd_hazard;
      end
    end
  end

  // Checks start once the reset synchroniser has let go
  a_write_advance: assert property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && wres_n_s && !wen_n_s |=> waddr_q == addr_next($past(waddr_q)))
    else $error("write address did not advance");
  a_write_hold: assert property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && wres_n_s && wen_n_s |=> $stable(waddr_q) && !pa_vld_q)
    else $error("write address moved while disabled");
  a_read_float: assert property (@(posedge mclk) disable iff (!rst_ok)
    r_rise && ren_n_s |=> read_word_oe_n && (!$past(rres_n_s) || $stable(raddr_q)))
    else $error("read port active while disabled");
  a_write_reset_init: assert property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && !wres_n_s |=> waddr_q == `LDF_ADDR_INIT)
    else $error("write counter reset missed");
  a_read_reset_init: assert property (@(posedge mclk) disable iff (!rst_ok)
    r_rise && !rres_n_s |=> raddr_q == `LDF_ADDR_INIT)
    else $error("read counter reset missed");
  a_write_capture: assert property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && wres_n_s && !wen_n_s |=> pa_vld_q && pa_data_q == $past(wdata_s))
    else $error("write word not latched at its rise");
  a_write_commit_time: assert property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && pa_vld_q |=> pb_vld_q until_with (w_fall && mem.we))
    else $error("pending word lost before its falling edge");
  a_read_data_path: assert property (@(posedge mclk) disable iff (!rst_ok)
    rd_take |=> read_word_out == $past(mem.rd_data) && !read_word_oe_n)
    else $error("read word does not match array");
  a_read_invalid_flag: assert property (@(posedge mclk) disable iff (!rst_ok)
    rd_take && rd_hazard |=> !read_word_valid)
    else $error("hazard read marked valid");
  a_read_valid_ok: assert property (@(posedge mclk) disable iff (!rst_ok)
    rd_take && !rd_hazard |=> read_word_valid)
    else $error("completed word marked invalid");
  a_write_wrap_zero: assert property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && wres_n_s && !wen_n_s && waddr_q == ldf_addr_t'(DEPTH - 1) |=>
      waddr_q == `LDF_ADDR_INIT)
    else $error("write address did not wrap");
  a_addr_wrap_zero: assert property (@(posedge mclk) disable iff (!rst_ok)
    rd_take && raddr_q == ldf_addr_t'(DEPTH - 1) |=> raddr_q == `LDF_ADDR_INIT)
    else $error("read address did not wrap");

  c_write_commit: cover property (@(posedge mclk) disable iff (!rst_ok) commit);
  c_read_valid:   cover property (@(posedge mclk) disable iff (!rst_ok)
    rd_take && !rd_hazard);
  c_read_hazard:  cover property (@(posedge mclk) disable iff (!rst_ok) rd_take && rd_hazard);
  c_write_wrap:   cover property (@(posedge mclk) disable iff (!rst_ok)
    w_rise && !wen_n_s && wres_n_s && waddr_q == ldf_addr_t'(DEPTH - 1));
endmodule : ldf_line_delay

/* File: ldf_ctl_model.sv */
// Upstream logic model driving the write and read port pins of the line delay memory.
// Assumes its tasks are called one at a time, each just after an mclk rise.
`timescale 1ns/1ps
module ldf_ctl_model #(
  parameter int PH = 3
) (
  input  wire logic   mclk,                  // System clock
  output ldf_pkg::ldf_word_t write_word_in,  // Write data
  output logic        write_clock,           // Write port clock
  output logic        write_enable_n,        // Write enable
  output logic        write_counter_reset_n, // Write counter reset
  output logic        read_clock,            // Read port clock
  output logic        read_enable_n,         // Read enable
  output logic        read_counter_reset_n   // Read counter reset
);
  import ldf_pkg::*;

  initial begin
    {write_clock, read_clock} = 2'b00;
    {write_enable_n, write_counter_reset_n, read_enable_n, read_counter_reset_n} = 4'hf;
    write_word_in = 8'h5a;
  end

  // Clocks stand low between cycles; enables held short, far under retention
  task automatic wr_cycle(input logic en_n, input logic crst_n, input ldf_word_t d);
    write_enable_n        <= en_n;
    write_counter_reset_n <= crst_n;
    write_word_in         <= d;
    repeat (PH) @(posedge mclk);
    write_clock <= 1'b1;
    repeat (PH) @(posedge mclk);
    write_clock   <= 1'b0;
    // Hold time over: data no longer valid, show its inverse
    write_word_in <= ~d;
    @(posedge mclk);
  endtask : wr_cycle

  task automatic rd_cycle(input logic en_n, input logic crst_n);
    read_enable_n        <= en_n;
    read_counter_reset_n <= crst_n;
    repeat (PH) @(posedge mclk);
    read_clock <= 1'b1;
    repeat (PH) @(posedge mclk);
    read_clock <= 1'b0;
    @(posedge mclk);
  endtask : rd_cycle
endmodule : ldf_ctl_model

/* File: tb_top.sv */
// Self-checking bench for the line delay memory, with a shadow array of expected words.
// Assumes the design and the upstream model share mclk; run length about 60k cycles.
`timescale 1ns/1ps
module tb_top;
  import ldf_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wclk, wen_n, wrst_n, rclk, ren_n, rrst_n, oe_n, vld;
  ldf_word_t   wd, rq, last, keep;
  ldf_word_t   shadow [8192];
  ldf_addr_t   wa, ra;
  logic [19:0] expq [$];
  logic [31:0] seed = 32'd75308;
  int          n_fail = 0;
  int          checks_done = 0;

  always #4 mclk = ~mclk;

  ldf_ctl_model pm_u (.mclk(mclk), .write_word_in(wd), .write_clock(wclk),
    .write_enable_n(wen_n), .write_counter_reset_n(wrst_n), .read_clock(rclk),
    .read_enable_n(ren_n), .read_counter_reset_n(rrst_n));
  ldf_line_delay dut_u (.mclk(mclk), .rst_n(rst_n), .write_clock(wclk),
    .write_enable_n(wen_n), .write_counter_reset_n(wrst_n), .write_word_in(wd),
    .read_clock(rclk), .read_enable_n(ren_n), .read_counter_reset_n(rrst_n),
    .read_word_oe_n(oe_n), .read_word_out(rq), .read_word_valid(vld));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic en_n);
    seed = xs(seed);
    if (!en_n) begin
      shadow[wa] = seed[7:0];
      wa = wa + 13'h1;
    end
    pm_u.wr_cycle(en_n, 1'b1, seed[7:0]);
  endtask : wr

  // Valid bit is not judged on disabled reads
  task automatic rd(input logic en_n, input logic v);
    if (!en_n) begin
      last = shadow[ra];
      ra = ra + 13'h1;
    end
    expq.push_back({en_n ? 10'h2ff : 10'h3ff, en_n, v, last});
    pm_u.rd_cycle(en_n, 1'b1);
  endtask : rd

  task automatic resets();
    wa = 13'h0;
    ra = 13'h0;
    pm_u.wr_cycle(1'b1, 1'b0, 8'h00);
    expq.push_back({10'h2ff, 2'b10, last});
    pm_u.rd_cycle(1'b1, 1'b0);
  endtask : resets

  initial begin
    logic [19:0] e;
    forever begin
      @(posedge rclk);
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      e = (expq.size() > 0) ? expq.pop_front() : 20'hfffff;
      checks_done++;
      if (({oe_n, vld, rq} & e[19:10]) !== (e[9:0] & e[19:10])) begin
        n_fail++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e[9:0], {oe_n, vld, rq});
      end
    end
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    $display("ERROR t=%0t exp=%h got=%h", $time, 1'b0, 1'b1);
    conclude();
  end

  initial begin
    last = 8'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    resets();
    for (int i = 0; i < 8; i++) wr(i == 3);
    wr(1'b1);
    wr(1'b1);
    for (int i = 0; i < 8; i++) rd(i == 2, 1'b1);
    resets();
    keep = shadow[0];
    wr(1'b0);
    {keep, shadow[0]} = {shadow[0], keep};
    rd(1'b0, 1'b0);
    shadow[0] = keep;
    wr(1'b1);
    wr(1'b1);
    ra = 13'h0;
    expq.push_back({10'h2ff, 2'b10, last});
    pm_u.rd_cycle(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    for (int i = 0; i < 8192; i++) wr(1'b0);
    wr(1'b1);
    wr(1'b1);
    ra = 13'h0;
    expq.push_back({10'h2ff, 2'b10, last});
    pm_u.rd_cycle(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    rd(1'b0, 1'b1);
    for (int i = 0; i < 40 && expq.size() > 0; i++) @(posedge mclk);
    checks_done++;
    if (expq.size() != 0) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 0, expq.size());
    end
    conclude();
  end
endmodule : tb_top
